// File: ssp_pkg.sv
// Constants and types shared by the serial programming port design
package ssp_pkg;

	// ****************************************************************
	// Clock and wait times
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FLASH_WAIT_US  = 4500;   // flash_page_wait_delay
	localparam int EEPROM_WAIT_US = 3600;   // eeprom_byte_wait_delay
	localparam int ERASE_WAIT_US  = 9000;   // erase_wait_delay
	localparam int FLASH_WAIT_CYC  = (FLASH_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EEPROM_WAIT_CYC = (EEPROM_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_WAIT_CYC  = (ERASE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// Widths and sizes
	// ****************************************************************
	localparam int TIMER_W   = 20;
	localparam int FLASH_AW  = 13;          // Word address
	localparam int PAGE_AW   = 6;           // Word within a page
	localparam int PAGE_NW   = 7;           // Page number
	localparam int EE_AW     = 10;          // EEPROM byte address
	localparam int SWEEP_W   = 14;
	localparam int FLASH_WORDS = 8192;
	localparam int EE_BYTES    = 1024;
	localparam int PAGE_WORDS  = 64;

	// ****************************************************************
	// Instruction encodings and field positions
	// ****************************************************************
	localparam logic [7:0] OPC_ENABLE_B0 = 8'hac;
	localparam logic [7:0] OPC_ENABLE_B1 = 8'h53;
	localparam logic [2:0] OPC_ERASE_B1  = 3'h4;  // Byte two, bits 7:5
	localparam logic [3:0] OPC_READ_PM   = 4'h2;  // Byte one, bits 7:4
	localparam logic [3:0] OPC_LOAD_PM   = 4'h4;  // Byte one, bits 7:4
	localparam logic [7:0] OPC_WRITE_PG  = 8'h4c;
	localparam logic [7:0] OPC_READ_EE   = 8'ha0;
	localparam logic [7:0] OPC_WRITE_EE  = 8'hc0;
	localparam logic [7:0] OPC_POLL      = 8'hf0;
	localparam int         HSEL_BIT      = 3;     // High or low byte select
	localparam logic [7:0] ERASED_BYTE   = 8'hff;
	localparam logic [15:0] ERASED_WORD  = 16'hffff;
	localparam logic [7:0] TX_IDLE       = 8'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {SSP_OP_IDLE, SSP_OP_FLASH, SSP_OP_EEPROM, SSP_OP_ERASE} ssp_op_t;
	typedef enum logic {SSP_LOCKED, SSP_ENABLED} ssp_mode_t;

endpackage

// File: ssp_link.sv
// Serial link front end: pin synchronisers, byte shifter in and out
`timescale 1ns/100ps
`default_nettype none
module ssp_link (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// Pins from the programmer
	input  wire logic       i_rst_pin_n,
	input  wire logic       i_sck,
	input  wire logic       i_mosi,
	// Byte to send next
	input  wire logic [7:0] i_tx_byte,
	// Received bytes
	output logic [7:0]      o_rx_byte,
	output logic            o_rx_valid,
	output logic [1:0]      o_rx_idx,
	output logic [1:0]      o_next_idx,
	output logic            o_pin_high,
	// Serial output
	output logic            o_miso
);
	import ssp_pkg::*;

	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	logic [2:0] sck_s;
	logic [1:0] mosi_s;
	logic [1:0] rst_s;
	logic [2:0] bit_cnt;
	logic [1:0] byte_idx;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;

	// Two flops per pin, a third on the clock for edge finding
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sck_s  <= 3'h0;
			mosi_s <= 2'h0;
			rst_s  <= 2'h3;
		end else begin
			sck_s  <= {sck_s[1:0], i_sck};
			mosi_s <= {mosi_s[0], i_mosi};
			rst_s  <= {rst_s[0], i_rst_pin_n};
		end
	end

	// Edges rely on each clock phase lasting at least three cycles
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire pin_high = rst_s[1];

	// ****************************************************************
	// Shifters
	// ****************************************************************
	// Sample on rising edge, MSB first; drive on falling edge
	always_ff @(posedge i_clk) begin
		if (i_srst || pin_high) begin
			bit_cnt    <= 3'h0;
			byte_idx   <= 2'h0;
			rx_sh      <= 8'h00;
			tx_sh      <= TX_IDLE;
			o_rx_byte  <= 8'h00;
			o_rx_valid <= 1'b0;
			o_rx_idx   <= 2'h0;
		end else begin
			o_rx_valid <= 1'b0;
			if (sck_rise) begin
				rx_sh   <= {rx_sh[6:0], mosi_s[1]};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					o_rx_byte  <= {rx_sh[6:0], mosi_s[1]};
					o_rx_valid <= 1'b1;
					o_rx_idx   <= byte_idx;
					byte_idx   <= byte_idx + 2'h1;
				end
			end
			if (sck_fall) begin
				if (bit_cnt == 3'h0)
					tx_sh <= i_tx_byte;
				else
					tx_sh <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	assign o_next_idx = byte_idx;
	assign o_pin_high = pin_high;
	assign o_miso     = tx_sh[7];

endmodule
`default_nettype wire

// File: ssp_prog.sv
// Serial programming port: instruction decode, page buffer, memories, write timing
// Summary of operation
// - With reset pin low, program and erase are refused until Programming Enable.
// - Each EEPROM byte write replaces the old byte, no prior erase needed.
// - Chip erase sets every flash and EEPROM location to 0xff.
// - Incoming bits are sampled on the rising SCK edge.
// - Outgoing bits change on the falling SCK edge.
// - In sync, 0x53 returns on MISO during third Programming Enable byte.
// - Page buffer loads one byte per instruction, six-bit word address, low first.
// - Write page commits the buffer to the page the high address bits select.
// - Once enabled, read returns the addressed flash or EEPROM byte during the fourth byte.
// - Reads inside a page being written return 0xff until it completes.
// - Read of an EEPROM byte being written returns 0xff until done.
// - Enable is 0xac 0x53; erase is 0xac then 100x xxxx.
// - Read program memory is 0010 H000, word address in bytes two, three.
// - Load page is 0100 H000 with address and data; write page 0x4c.
// - Read EEPROM is 0xa0, address in bytes two and three.
`timescale 1ns/100ps
`default_nettype none
module ssp_prog #(
	parameter int FLASH_CYC  = ssp_pkg::FLASH_WAIT_CYC,
	parameter int EEPROM_CYC = ssp_pkg::EEPROM_WAIT_CYC,
	parameter int ERASE_CYC  = ssp_pkg::ERASE_WAIT_CYC
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Programming pins
	input  wire logic i_rst_pin_n,
	input  wire logic i_sck,
	input  wire logic i_mosi,
	output logic      o_miso,
	// Status
	output logic      o_prog_enabled,
	output logic      o_busy
);
	import ssp_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Page number carried by bytes two and three
	function automatic logic [PAGE_NW-1:0] page_of(input logic [7:0] hi, input logic [7:0] lo);
		page_of = {hi[4:0], lo[7:6]};
	endfunction

	// Programming Enable match
	function automatic logic is_enable(input logic [7:0] c0, input logic [7:0] c1);
		is_enable = (c0 == OPC_ENABLE_B0) && (c1 == OPC_ENABLE_B1);
	endfunction

	// Chip erase match, low five bits of byte two free
	function automatic logic is_erase(input logic [7:0] c0, input logic [7:0] c1);
		is_erase = (c0 == OPC_ENABLE_B0) && (c1[7:5] == OPC_ERASE_B1);
	endfunction

	// Opcode class in the high nibble with bits 2:0 clear, byte select free
	function automatic logic is_hsel_op(input logic [7:0] c0, input logic [3:0] cls);
		is_hsel_op = (c0[7:4] == cls) && (c0[2:0] == 3'h0);
	endfunction

	// Read program memory match, H bit free
	function automatic logic is_read_pm(input logic [7:0] c0);
		is_read_pm = is_hsel_op(c0, OPC_READ_PM);
	endfunction

	// ****************************************************************
	// Signals
	// ****************************************************************
	// Link side
	logic [7:0]         rx_byte;
	logic               rx_valid;
	logic [1:0]         rx_idx;
	logic [1:0]         next_idx;
	logic               pin_high;

	// First three bytes of the instruction in flight
	logic [7:0]         b0;
	logic [7:0]         b1;
	logic [7:0]         b2;

	// Enable state and self-timed operation
	ssp_mode_t          mode;
	ssp_op_t            op;
	logic [TIMER_W-1:0] timer;
	logic [SWEEP_W-1:0] sweep;
	logic [PAGE_NW-1:0] pend_page;
	logic [EE_AW-1:0]   pend_ee;

	// Storage arrays and the outgoing byte
	logic [15:0]        flash_mem [0:FLASH_WORDS-1];
	logic [7:0]         ee_mem    [0:EE_BYTES-1];
	logic [15:0]        page_buf  [0:PAGE_WORDS-1];
	logic [7:0]         next_tx;

	// ****************************************************************
	// Link front end
	// ****************************************************************
	ssp_link u_link (
		.i_clk       (i_clk),
		.i_srst      (i_srst),
		.i_rst_pin_n (i_rst_pin_n),
		.i_sck       (i_sck),
		.i_mosi      (i_mosi),
		.i_tx_byte   (next_tx),
		.o_rx_byte   (rx_byte),
		.o_rx_valid  (rx_valid),
		.o_rx_idx    (rx_idx),
		.o_next_idx  (next_idx),
		.o_pin_high  (pin_high),
		.o_miso      (o_miso)
	);

	// ****************************************************************
	// Instruction decode
	// ****************************************************************
	// Addresses and opcode classes of the instruction in flight
	wire [FLASH_AW-1:0] fl_addr  = {b1[4:0], b2};
	wire [EE_AW-1:0]    ee_addr  = {b1[1:0], b2};
	wire [PAGE_NW-1:0]  rd_page  = page_of(b1, b2);
	wire [PAGE_AW-1:0]  ld_word  = b2[PAGE_AW-1:0];
	wire                hsel     = b0[HSEL_BIT];
	wire                enabled  = (mode == SSP_ENABLED);
	wire                busy     = (op != SSP_OP_IDLE);
	wire                last_b   = rx_valid && (rx_idx == 2'h3);
	wire                dec_en   = is_enable(b0, b1);
	wire                dec_er   = is_erase(b0, b1);
	wire                dec_rpm  = is_read_pm(b0);
	wire                dec_lpm  = is_hsel_op(b0, OPC_LOAD_PM);
	wire                dec_wpg  = (b0 == OPC_WRITE_PG);
	wire                dec_ree  = (b0 == OPC_READ_EE);
	wire                dec_wee  = (b0 == OPC_WRITE_EE);
	wire                dec_poll = (b0 == OPC_POLL);

	// Commands act on the fourth byte; writes need idle and enable at that byte
	// A load, write or erase that meets a busy array is dropped; the programmer must poll or wait
	wire                go       = last_b && enabled && !busy;
	wire                do_erase = go && dec_er;
	wire                do_load  = go && dec_lpm;
	wire                do_wpage = go && dec_wpg;
	wire                do_wee   = go && dec_wee;

	// ****************************************************************
	// Read path
	// ****************************************************************
	// A page or byte under write, or the whole array under erase, reads as erased
	// Reads stay legal while busy, which is what lets the programmer poll
	wire [15:0] fl_word   = flash_mem[fl_addr];
	wire        fl_hidden = ((op == SSP_OP_FLASH) && (rd_page == pend_page)) || (op == SSP_OP_ERASE);
	wire [7:0]  fl_byte   = fl_hidden ? ERASED_BYTE : (hsel ? fl_word[15:8] : fl_word[7:0]);
	wire        ee_hidden = ((op == SSP_OP_EEPROM) && (ee_addr == pend_ee)) || (op == SSP_OP_ERASE);
	wire [7:0]  ee_byte   = ee_hidden ? ERASED_BYTE : ee_mem[ee_addr];

	// Byte loaded into the output shifter for the coming slot
	always_comb begin
		next_tx = TX_IDLE;
		if (next_idx == 2'h1)
			next_tx = b0;
		else if (next_idx == 2'h2)
			next_tx = b1;
		else if (next_idx == 2'h3) begin
			if (enabled && dec_rpm)
				next_tx = fl_byte;
			else if (enabled && dec_ree)
				next_tx = ee_byte;
			else if (dec_poll)
				next_tx = {7'h00, busy};
			else
				next_tx = b2;
		end
	end

	// ****************************************************************
	// Instruction byte capture and enable state
	// ****************************************************************
	// Hold the first three bytes of the current instruction
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			b0 <= 8'h00;
			b1 <= 8'h00;
			b2 <= 8'h00;
		end else if (rx_valid) begin
			if (rx_idx == 2'h0)
				b0 <= rx_byte;
			else if (rx_idx == 2'h1)
				b1 <= rx_byte;
			else if (rx_idx == 2'h2)
				b2 <= rx_byte;
		end
	end

	// Enable is lost whenever the reset pin rises
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mode <= SSP_LOCKED;
		end else begin
			case (mode)
				SSP_LOCKED: begin
					if (!pin_high && last_b && dec_en)
						mode <= SSP_ENABLED;
				end
				default: begin
					if (pin_high)
						mode <= SSP_LOCKED;
				end
			endcase
		end
	end

	// ****************************************************************
	// Self-timed operation sequencer
	// ****************************************************************
	// Runs the wait timer and a sweep index that walks the cells to change
	// The timer spans the whole wait; the sweep ends long before it runs out
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			op        <= SSP_OP_IDLE;
			timer     <= '0;
			sweep     <= '0;
			pend_page <= '0;
			pend_ee   <= '0;
		end else begin
			case (op)
				SSP_OP_IDLE: begin
					sweep <= '0;
					if (do_erase) begin
						op    <= SSP_OP_ERASE;
						timer <= TIMER_W'(ERASE_CYC);
					end else if (do_wpage) begin
						op        <= SSP_OP_FLASH;
						timer     <= TIMER_W'(FLASH_CYC);
						pend_page <= rd_page;
					end else if (do_wee) begin
						op      <= SSP_OP_EEPROM;
						timer   <= TIMER_W'(EEPROM_CYC);
						pend_ee <= ee_addr;
					end
				end
				default: begin
					if (!sweep[SWEEP_W-1])
						sweep <= sweep + 14'h0001;
					timer <= timer - 20'h00001;
					if (timer == 20'h00001)
						op <= SSP_OP_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Memory arrays
	// ****************************************************************
	wire erase_step = (op == SSP_OP_ERASE) && !sweep[SWEEP_W-1];
	wire ee_in_rng  = (sweep[SWEEP_W-2:EE_AW] == 3'h0);
	wire page_step  = (op == SSP_OP_FLASH) && (sweep[SWEEP_W-1:PAGE_AW] == 8'h00);
	wire [FLASH_AW-1:0] commit_addr = {pend_page, sweep[PAGE_AW-1:0]};

	// Flash cells; erase and page commit sweep one word a cycle
	always_ff @(posedge i_clk) begin
		if (erase_step)
			flash_mem[sweep[FLASH_AW-1:0]] <= ERASED_WORD;
		else if (page_step)
			flash_mem[commit_addr] <= page_buf[sweep[PAGE_AW-1:0]];
	end

	// EEPROM cells; a byte write overwrites in place, erase clears the low sweep range
	always_ff @(posedge i_clk) begin
		if (erase_step && ee_in_rng)
			ee_mem[sweep[EE_AW-1:0]] <= ERASED_BYTE;
		else if (do_wee)
			ee_mem[ee_addr] <= rx_byte;
	end

	// Page buffer: byte loads, refilled with erased words as each is committed
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			for (int i = 0; i < PAGE_WORDS; i++)
				page_buf[i] <= ERASED_WORD;
		end else if (page_step) begin
			page_buf[sweep[PAGE_AW-1:0]] <= ERASED_WORD;
		end else if (do_load) begin
			if (hsel)
				page_buf[ld_word][15:8] <= rx_byte;
			else
				page_buf[ld_word][7:0] <= rx_byte;
		end
	end

	// ****************************************************************
	// Status outputs
	// ****************************************************************
	// Busy covers every self-timed operation, so it also feeds the poll reply
	assign o_prog_enabled = enabled;
	assign o_busy         = busy;

endmodule
`default_nettype wire

// File: ssp_prog_asserts.sv
// Concurrent checks on the serial programming port pins
`timescale 1ns/100ps
`default_nettype none
module ssp_prog_asserts #(
	parameter int FLASH_CYC  = 450000,
	parameter int EEPROM_CYC = 360000,
	parameter int ERASE_CYC  = 900000
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Programming pins
	input  wire logic i_rst_pin_n,
	input  wire logic i_sck,
	input  wire logic i_mosi,
	input  wire logic o_miso,
	// Status
	input  wire logic o_prog_enabled,
	input  wire logic o_busy
);
	// ****
	// Helper logic
	// ****
	logic       sck_q;
	logic [3:0] rise_age;
	logic [3:0] fall_age;
	logic [3:0] low_age;
	int         busy_cnt;

	// Cycles since the last SCK edges, reset pin low time, busy length
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sck_q    <= 1'b0;
			rise_age <= 4'hf;
			fall_age <= 4'hf;
			low_age  <= 4'h0;
			busy_cnt <= 0;
		end else begin
			sck_q    <= i_sck;
			rise_age <= (i_sck && !sck_q) ? 4'h0 : ((&rise_age) ? rise_age : rise_age + 4'h1);
			fall_age <= (!i_sck && sck_q) ? 4'h0 : ((&fall_age) ? fall_age : fall_age + 4'h1);
			low_age  <= i_rst_pin_n ? 4'h0 : ((&low_age) ? low_age : low_age + 4'h1);
			busy_cnt <= o_busy ? busy_cnt + 1 : 0;
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_reset_quiet;
		$fell(i_srst) |-> !o_busy && !o_prog_enabled && !o_miso;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

	property p_busy_needs_enable;
		$rose(o_busy) |-> o_prog_enabled;
	endproperty
	a_busy_needs_enable: assert property (p_busy_needs_enable) else $error("operation started while locked");

	property p_enable_clear;
		i_rst_pin_n [*5] |-> !o_prog_enabled;
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable kept with reset pin high");

	property p_enable_after_rise;
		$rose(o_prog_enabled) |-> rise_age <= 4'h7 && low_age >= 4'h4;
	endproperty
	a_enable_after_rise: assert property (p_enable_after_rise) else $error("enable not tied to an SCK rise");

	property p_busy_after_rise;
		$rose(o_busy) |-> rise_age <= 4'h7;
	endproperty
	a_busy_after_rise: assert property (p_busy_after_rise) else $error("busy not tied to an SCK rise");

	property p_miso_on_fall;
		$changed(o_miso) && low_age >= 4'h8 |-> fall_age >= 4'h1 && fall_age <= 4'h5;
	endproperty
	a_miso_on_fall: assert property (p_miso_on_fall) else $error("output bit moved away from SCK fall");

	property p_miso_cleared;
		i_rst_pin_n [*5] |-> !o_miso;
	endproperty
	a_miso_cleared: assert property (p_miso_cleared) else $error("output bit not cleared by reset pin");

	property p_busy_len;
		$fell(o_busy) |-> busy_cnt inside {[FLASH_CYC-1:FLASH_CYC+1], [EEPROM_CYC-1:EEPROM_CYC+1],
			[ERASE_CYC-1:ERASE_CYC+1]};
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length not a timer count");

	property p_busy_max;
		o_busy |-> busy_cnt <= ERASE_CYC + 1;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy held too long");
endmodule

bind ssp_prog ssp_prog_asserts #(.FLASH_CYC(FLASH_CYC), .EEPROM_CYC(EEPROM_CYC), .ERASE_CYC(ERASE_CYC))
	u_ssp_prog_asserts (.i_clk(i_clk), .i_srst(i_srst), .i_rst_pin_n(i_rst_pin_n), .i_sck(i_sck),
	.i_mosi(i_mosi), .o_miso(o_miso), .o_prog_enabled(o_prog_enabled), .o_busy(o_busy));
`default_nettype wire

// File: ssp_prog_model.sv
// Behavioural programmer acting as the serial master
`timescale 1ns/100ps
`default_nettype none
module ssp_prog_model #(
	parameter int HALF_CYC    = 8,   // SCK low time in clock cycles; the high time is one cycle more
	parameter int POWERUP_CYC = 20   // Shortened power-up wait
) (
	// Clock
	input  wire logic i_clk,
	// Programming pins
	output logic      o_rst_pin_n,
	output logic      o_sck,
	output logic      o_mosi,
	input  wire logic i_miso
);
	// Power-up with reset pin and SCK low
	initial begin
		o_rst_pin_n = 1'b0;
		o_sck = 1'b0;
		o_mosi = 1'b0;
	end

	// Reset pin pulse to regain byte framing, then the power-up wait
	task automatic pulse_reset();
		@(negedge i_clk) o_rst_pin_n = 1'b1;
		repeat (4) @(negedge i_clk);
		o_rst_pin_n = 1'b0;
		repeat (POWERUP_CYC) @(negedge i_clk);
	endtask

	// Whole four-byte instruction, data set while SCK low, reply taken at the rise
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
		for (int i = 31; i >= 0; i--) begin
			@(negedge i_clk) o_sck = 1'b0;
			o_mosi = cmd[i];
			repeat (HALF_CYC) @(negedge i_clk);
			o_sck = 1'b1;
			rsp[i] = i_miso;
			repeat (HALF_CYC) @(negedge i_clk);
		end
		@(negedge i_clk) o_sck = 1'b0;
		o_mosi = ~o_mosi; // Line inverted so it shows no stale value
	endtask
endmodule
`default_nettype wire

// File: test_ssp_prog.sv
// Self-checking testbench for the serial programming port
`timescale 1ns/100ps
`default_nettype none
module test_ssp_prog;
	import ssp_pkg::*;
	localparam int FL_CYC = 2000;
	localparam int EE_CYC = 1500;
	localparam int ER_CYC = 8200;
	logic        i_clk;
	logic        i_srst;
	logic        rst_pin_n;
	logic        sck;
	logic        mosi;
	logic        miso;
	logic        prog_enabled;
	logic        busy;
	logic [31:0] rsp;
	int          error_cnt = 0;
	int          checks_done = 0;

	// ****
	// Design, programmer, clock
	// ****
	ssp_prog #(.FLASH_CYC(FL_CYC), .EEPROM_CYC(EE_CYC), .ERASE_CYC(ER_CYC)) i_ssp_prog (
		.i_clk(i_clk), .i_srst(i_srst), .i_rst_pin_n(rst_pin_n), .i_sck(sck), .i_mosi(mosi),
		.o_miso(miso), .o_prog_enabled(prog_enabled), .o_busy(busy));
	ssp_prog_model i_ssp_prog_model (.i_clk(i_clk), .o_rst_pin_n(rst_pin_n), .o_sck(sck),
		.o_mosi(mosi), .i_miso(miso));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ****
	// Shared tasks
	// ****
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic send(input logic [31:0] cmd);
		i_ssp_prog_model.xfer(cmd, rsp);
	endtask

	// Bounded wait for the end of a write or erase
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge i_clk);
			n++;
		end
		chk("busy_end", {7'h0, busy}, 8'h00);
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_locked();
		i_ssp_prog_model.pulse_reset();
		send({OPC_ENABLE_B0, 8'h80, 16'h0000});
		send({OPC_WRITE_PG, 24'h000000});
		repeat (10) @(negedge i_clk);
		chk("busy_locked", {7'h0, busy}, 8'h00);
		chk("enabled_locked", {7'h0, prog_enabled}, 8'h00);
	endtask

	task automatic t_enable();
		send({OPC_ENABLE_B0, OPC_ENABLE_B1, 16'h0000});
		chk("echo_byte1", rsp[23:16], OPC_ENABLE_B0);
		chk("echo_byte2", rsp[15:8], OPC_ENABLE_B1);
		repeat (6) @(negedge i_clk);
		chk("enabled", {7'h0, prog_enabled}, 8'h01);
		send({OPC_ENABLE_B0, 8'ha0, 16'h00ff});
		repeat (8) @(negedge i_clk);
		chk("busy_not_erase", {7'h0, busy}, 8'h00);
	endtask

	task automatic t_erase();
		send({OPC_ENABLE_B0, 8'h9f, 16'hffff});
		repeat (8) @(negedge i_clk);
		chk("busy_erase", {7'h0, busy}, 8'h01);
		send({OPC_POLL, 24'h000000});
		chk("poll_busy", {7'h0, rsp[0]}, 8'h01);
		wait_idle();
		send({OPC_READ_PM, 4'h0, 24'h000000});
		chk("erased_low", rsp[7:0], 8'hff);
		send({OPC_READ_PM, 4'h8, 24'h1fff00});
		chk("erased_high", rsp[7:0], 8'hff);
		send({OPC_READ_EE, 24'h03ff00});
		chk("erased_ee", rsp[7:0], 8'hff);
	endtask

	task automatic t_flash();
		send({OPC_LOAD_PM, 4'h0, 24'h00055a});
		send({OPC_LOAD_PM, 4'h8, 24'h0005a5});
		send({OPC_WRITE_PG, 24'h00c000});
		send({OPC_READ_PM, 4'h0, 24'h00c500});
		chk("page_busy", rsp[7:0], 8'hff);
		wait_idle();
		send({OPC_READ_PM, 4'h0, 24'h00c500});
		chk("page_low", rsp[7:0], 8'h5a);
		send({OPC_READ_PM, 4'h8, 24'h00c500});
		chk("page_high", rsp[7:0], 8'ha5);
		send({OPC_READ_PM, 4'h0, 24'h000500});
		chk("other_page", rsp[7:0], 8'hff);
	endtask

	task automatic t_eeprom();
		send({OPC_WRITE_EE, 24'h03fe3c});
		send({OPC_READ_EE, 24'h03fe00});
		chk("ee_busy", rsp[7:0], 8'hff);
		wait_idle();
		send({OPC_READ_EE, 24'h03fe00});
		chk("ee_first", rsp[7:0], 8'h3c);
		send({OPC_WRITE_EE, 24'h03fec3});
		wait_idle();
		send({OPC_READ_EE, 24'h03fe00});
		chk("ee_rewrite", rsp[7:0], 8'hc3);
	endtask

	// ****
	// Main sequence and watchdog
	// ****
	initial begin
		i_srst = 1'b1;
		repeat (6) @(negedge i_clk);
		i_srst = 1'b0;
		t_locked();
		t_enable();
		t_erase();
		t_flash();
		t_eeprom();
		wrap_up();
	end

	initial begin
		#600000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
